// *** common/mm_value_pkg.sv ***
package mm_value_pkg;

    // Clock and integration timing
    localparam int CLOCK_MHZ     = 10;
    localparam int INTEG_50_US   = 20000;
    localparam int INTEG_60_US   = 16660;
    localparam int INTEG_50_CYC  = INTEG_50_US * CLOCK_MHZ;
    localparam int INTEG_60_CYC  = INTEG_60_US * CLOCK_MHZ;

    // Averaging
    localparam logic [2:0] AVG_LAST  = 3'h7;
    localparam int         AVG_SHIFT = 3;

    // Register byte addresses
    localparam logic [7:0] CFG_OFS       = 8'h00;
    localparam logic [7:0] STATUS_OFS    = 8'h04;
    localparam logic [7:0] VALUE_OFS     = 8'h08;
    localparam logic [7:0] ZERO_NOW_OFS  = 8'h0C;
    localparam logic [7:0] CAL_ZERO_OFS  = 8'h10;
    localparam logic [7:0] M60_OFF_OFS   = 8'h14;
    localparam logic [7:0] M60_GAIN_OFS  = 8'h18;
    localparam logic [7:0] VND_OFF_OFS   = 8'h1C;
    localparam logic [7:0] VND_GAIN_OFS  = 8'h20;
    localparam logic [7:0] AC_SO_OFS     = 8'h24;
    localparam logic [7:0] USER_BASE_OFS = 8'h40;
    localparam logic [3:0] USER_PAIRS    = 4'hE;

    // Feature configuration fields
    localparam int CFG_FILTER_BIT = 0;
    localparam int CFG_VENDOR_BIT = 1;
    localparam int CFG_USER_BIT   = 2;
    localparam int CFG_M60_BIT    = 3;
    localparam int CFG_PRES_LSB   = 4;
    localparam int CFG_ZCI_LSB    = 8;
    localparam logic [31:0] CFG_RESET  = 32'h0000_0023;
    localparam logic [31:0] CFG_MASK   = 32'h0000_07FF;
    localparam logic [15:0] GAIN_RESET = 16'h2000;

    // Presentation codes and zero-compensation settings
    localparam logic [3:0] PRES_LEFT   = 4'h0;
    localparam logic [3:0] PRES_RIGHT  = 4'h1;
    localparam logic [3:0] PRES_SCALED = 4'h2;
    localparam logic [3:0] PRES_FLOAT  = 4'h5;
    localparam logic [2:0] ZCI_OFF     = 3'h0;
    localparam logic [2:0] ZCI_PDO     = 3'h4;

    // Range codes
    localparam logic [2:0] R_300MV = 3'h0;
    localparam logic [2:0] R_3V    = 3'h1;
    localparam logic [2:0] R_30V   = 3'h2;
    localparam logic [2:0] R_300V  = 3'h3;
    localparam logic [2:0] R_100MA = 3'h4;
    localparam logic [2:0] R_1A    = 3'h5;
    localparam logic [2:0] R_10A   = 3'h6;
    localparam logic [3:0] RANGES  = 4'h7;

    // Limits in converter counts, full scale = 2^18
    localparam int FS_POS    = 262143;
    localparam int FS_NEG    = -262144;
    localparam int EXT_LIMIT = 262144 * 115 / 100;
    localparam int UP_LIMIT  = 262144 * 110 / 100;
    localparam int DN_LIMIT  = 262144 * 10 / 100;
    localparam int DN_LEFT   = 262144 * 5 / 100;
    localparam int SCALE_SHIFT = 18;
    localparam int FSCAL_VOLT  = 300000;
    localparam int FSCAL_AMP   = 100000;
    localparam int LEFT_SHIFT  = 13;
    localparam logic [31:0] LEFT_MAX = 32'h7FFF_FFFF;
    localparam logic [31:0] LEFT_MIN = 32'h8000_0000;

    typedef enum logic [2:0] {
        S_IDLE = 3'b000,
        S_M60  = 3'b001,
        S_VND  = 3'b011,
        S_USR  = 3'b010,
        S_ACO  = 3'b110,
        S_CHK  = 3'b111
    } proc_state_t;

endpackage

// *** hw/mm_value_proc.sv ***
module mm_value_proc
    import mm_value_pkg::*;
#(
    parameter int INTEG_50_CYCLES = INTEG_50_CYC,
    parameter int INTEG_60_CYCLES = INTEG_60_CYC
)(
    input  wire logic               i_clock,
    input  wire logic               i_rst_n,
    input  wire logic [7:0]         i_addr,
    input  wire logic [31:0]        i_wdata,
    input  wire logic               i_wr,
    input  wire logic               i_rd,
    output logic      [31:0]        o_rdata,
    input  wire logic               i_conv_valid,
    input  wire logic signed [23:0] i_conv_raw,
    input  wire logic [2:0]         i_conv_range,
    input  wire logic               i_zero_valid,
    input  wire logic signed [23:0] i_zero_value,
    output logic                    o_conv_start,
    output logic [2:0]              o_conv_range,
    output logic                    o_conv_ac,
    output logic                    o_conv_60hz,
    output logic                    o_zero_read,
    input  wire logic [2:0]         i_range_req,
    input  wire logic               i_autorange,
    input  wire logic               i_ac_mode,
    input  wire logic               i_offset_trigger,
    output logic [31:0]             o_value,
    output logic                    o_value_valid,
    output logic                    o_under,
    output logic                    o_over,
    output logic                    o_invalid,
    output logic                    o_error
);

    function automatic logic signed [31:0] gain_stage(input logic signed [31:0] x,
                                                     input logic signed [31:0] b,
                                                     input logic [15:0] a);
        logic signed [63:0] d;
        logic signed [63:0] p;
        d = 64'(x) - 64'(b);
        p = d * $signed({48'h0, a});
        return 32'((d - (d >>> 3)) + (p >>> 16));
    endfunction

    function automatic logic [31:0] to_float(input logic signed [31:0] v);
        logic [31:0] mag;
        logic [4:0]  pos;
        logic [31:0] norm;
        mag = v[31] ? 32'(-v) : 32'(v);
        pos = 5'h0;
        for (int i = 0; i < 32; i++)
        begin
            if (mag[i])
                pos = 5'(i);
        end
        norm = mag << (5'h1F - pos);
        if (mag == 32'h0)
            return 32'h0;
        return {v[31], 8'(127 + int'(pos)), norm[30:8]};
    endfunction

    function automatic logic [31:0] decade(input logic [2:0] r);
        unique case (r)
            R_300MV, R_100MA: return 32'h1;
            R_3V, R_1A:       return 32'hA;
            R_30V, R_10A:     return 32'h64;
            default:          return 32'h3E8;
        endcase
    endfunction

    // Configuration and calibration store
    logic [31:0]        cfg_q, cfg_d;
    logic signed [31:0] zero_now_q, zero_now_d;
    logic signed [31:0] cal_zero_q, cal_zero_d;
    logic signed [31:0] m60_off_q, m60_off_d;
    logic [15:0]        m60_gain_q, m60_gain_d;
    logic signed [31:0] vnd_off_q, vnd_off_d;
    logic [15:0]        vnd_gain_q, vnd_gain_d;
    logic signed [31:0] ac_so_q, ac_so_d;
    logic signed [31:0] user_off [14];
    logic [15:0]        user_gain [14];
    logic [31:0]        rdata_q, rdata_d;

    // Timing and processing state
    logic [17:0]        integ_q, integ_d;
    logic               start_q, start_d;
    logic [7:0]         zcnt_q, zcnt_d;
    logic               zread_q, zread_d;
    logic               trig_q, trig_d;
    proc_state_t        state_q, state_d;
    logic signed [34:0] acc_q, acc_d;
    logic [2:0]         cnt_q, cnt_d;
    logic signed [31:0] y_q, y_d;
    logic [2:0]         range_q, range_d;
    logic [2:0]         conv_rng_q, conv_rng_d;
    logic               ac_q, ac_d;
    logic [31:0]        value_q, value_d;
    logic               valid_q, valid_d;
    logic               under_q, under_d;
    logic               over_q, over_d;
    logic               inv_q, inv_d;
    logic               err_q, err_d;

    wire logic       filter_en = cfg_q[CFG_FILTER_BIT];
    wire logic       vnd_en    = cfg_q[CFG_VENDOR_BIT];
    wire logic       user_en   = cfg_q[CFG_USER_BIT];
    wire logic       mains60   = cfg_q[CFG_M60_BIT];
    wire logic [3:0] pres      = cfg_q[CFG_PRES_LSB +: 4];
    wire logic [2:0] zci       = cfg_q[CFG_ZCI_LSB +: 3];
    wire logic       zero_on   = (zci != ZCI_OFF);

    logic [7:0] uoff_addr;
    logic [3:0] uidx_bus;
    logic       user_hit;
    logic [3:0] uidx;
    assign uoff_addr = i_addr - USER_BASE_OFS;
    assign uidx_bus  = uoff_addr[6:3];
    assign user_hit  = (i_addr >= USER_BASE_OFS) && !uoff_addr[7] && (uidx_bus < USER_PAIRS);
    assign uidx      = ac_q ? 4'(range_q) + RANGES : 4'(range_q);

    // Register bus: writes and read answer
    always_comb
    begin
        cfg_d      = cfg_q;
        zero_now_d = zero_now_q;
        cal_zero_d = cal_zero_q;
        m60_off_d  = m60_off_q;
        m60_gain_d = m60_gain_q;
        vnd_off_d  = vnd_off_q;
        vnd_gain_d = vnd_gain_q;
        ac_so_d    = ac_so_q;
        rdata_d    = 32'h0;
        if (i_wr)
        begin
            unique case (i_addr)
                CFG_OFS:      cfg_d      = i_wdata & CFG_MASK;
                CAL_ZERO_OFS: cal_zero_d = i_wdata;
                M60_OFF_OFS:  m60_off_d  = i_wdata;
                M60_GAIN_OFS: m60_gain_d = i_wdata[15:0];
                VND_OFF_OFS:  vnd_off_d  = i_wdata;
                VND_GAIN_OFS: vnd_gain_d = i_wdata[15:0];
                AC_SO_OFS:    ac_so_d    = i_wdata;
                default:      cfg_d      = cfg_q;
            endcase
        end
        if (i_zero_valid)
            zero_now_d = 32'(i_zero_value);
        if (i_rd)
        begin
            unique case (i_addr)
                CFG_OFS:      rdata_d = cfg_q;
                STATUS_OFS:   rdata_d = {24'h0, ac_q, range_q,
                                         (under_q | over_q | inv_q), inv_q, over_q, under_q};
                VALUE_OFS:    rdata_d = value_q;
                ZERO_NOW_OFS: rdata_d = zero_now_q;
                CAL_ZERO_OFS: rdata_d = cal_zero_q;
                M60_OFF_OFS:  rdata_d = m60_off_q;
                M60_GAIN_OFS: rdata_d = {16'h0, m60_gain_q};
                VND_OFF_OFS:  rdata_d = vnd_off_q;
                VND_GAIN_OFS: rdata_d = {16'h0, vnd_gain_q};
                AC_SO_OFS:    rdata_d = ac_so_q;
                default:
                begin
                    if (user_hit)
                        rdata_d = uoff_addr[2] ? {16'h0, user_gain[uidx_bus]}
                                               : user_off[uidx_bus];
                end
            endcase
        end
    end

    always_ff @(posedge i_clock)
    begin
        if (!i_rst_n)
        begin
            cfg_q      <= CFG_RESET;
            zero_now_q <= 32'h0;
            cal_zero_q <= 32'h0;
            m60_off_q  <= 32'h0;
            m60_gain_q <= GAIN_RESET;
            vnd_off_q  <= 32'h0;
            vnd_gain_q <= GAIN_RESET;
            ac_so_q    <= 32'h0;
            rdata_q    <= 32'h0;
            for (int i = 0; i < 14; i++)
            begin
                user_off[i]  <= 32'h0;
                user_gain[i] <= GAIN_RESET;
            end
        end
        else
        begin
            cfg_q      <= cfg_d;
            zero_now_q <= zero_now_d;
            cal_zero_q <= cal_zero_d;
            m60_off_q  <= m60_off_d;
            m60_gain_q <= m60_gain_d;
            vnd_off_q  <= vnd_off_d;
            vnd_gain_q <= vnd_gain_d;
            ac_so_q    <= ac_so_d;
            rdata_q    <= rdata_d;
            if (i_wr && user_hit)
            begin
                if (uoff_addr[2])
                    user_gain[uidx_bus] <= i_wdata[15:0];
                else
                    user_off[uidx_bus] <= i_wdata;
            end
        end
    end

    // Integration timer and zero-offset read requests
    always_comb
    begin
        integ_d = integ_q - 18'h1;
        start_d = 1'b0;
        if (integ_q == 18'h0)
        begin
            integ_d = mains60 ? 18'(INTEG_60_CYCLES - 1) : 18'(INTEG_50_CYCLES - 1);
            start_d = 1'b1;
        end
        trig_d  = i_offset_trigger;
        zread_d = 1'b0;
        zcnt_d  = zcnt_q;
        if (zci == ZCI_PDO)
            zread_d = i_offset_trigger && !trig_q;
        else if (zero_on && zci < ZCI_PDO && i_conv_valid)
        begin
            zcnt_d = zcnt_q + 8'h1;
            if (zcnt_q >= (8'h1 << (zci + 3'h3)) - 8'h1)
            begin
                zcnt_d  = 8'h0;
                zread_d = 1'b1;
            end
        end
    end

    always_ff @(posedge i_clock)
    begin
        if (!i_rst_n)
        begin
            integ_q <= 18'h0;
            start_q <= 1'b0;
            trig_q  <= 1'b0;
            zread_q <= 1'b0;
            zcnt_q  <= 8'h0;
        end
        else
        begin
            integ_q <= integ_d;
            start_q <= start_d;
            trig_q  <= trig_d;
            zread_q <= zread_d;
            zcnt_q  <= zcnt_d;
        end
    end

    // Value pipeline, flags, ranging and presentation
    logic signed [31:0] x_corr;
    logic signed [34:0] acc_sum;
    logic signed [32:0] ac_twice;
    logic signed [31:0] mag;
    logic signed [63:0] scal_prod;
    logic signed [31:0] scaled;
    logic               has_larger;
    logic               has_smaller;
    logic signed [31:0] ovf_limit;

    always_comb
    begin
        state_d    = state_q;
        acc_d      = acc_q;
        cnt_d      = cnt_q;
        y_d        = y_q;
        range_d    = range_q;
        conv_rng_d = conv_rng_q;
        ac_d       = i_ac_mode;
        value_d    = value_q;
        valid_d    = 1'b0;
        under_d    = under_q;
        over_d     = over_q;
        inv_d      = inv_q;
        x_corr     = 32'(i_conv_raw);
        if (zero_on)
            x_corr = 32'(i_conv_raw) - (zero_now_q - cal_zero_q);
        acc_sum    = acc_q + 35'(x_corr);
        ac_twice   = 33'(ac_so_q) <<< 1;
        mag        = y_q[31] ? -y_q : y_q;
        scal_prod  = 64'(y_q) * ((range_q >= R_100MA) ? 64'(FSCAL_AMP) : 64'(FSCAL_VOLT));
        scaled     = 32'((scal_prod >>> SCALE_SHIFT) * 64'(decade(range_q)));
        has_larger  = (range_q != R_300V) && (range_q != R_1A) && (range_q != R_10A);
        has_smaller = (range_q != R_300MV) && (range_q != R_100MA) && (range_q != R_10A);
        ovf_limit   = (has_larger && pres != PRES_LEFT) ? 32'(EXT_LIMIT) : 32'(FS_POS);
        if (!i_autorange && i_range_req < 3'(RANGES))
            range_d = i_range_req;
        unique case (state_q)
            S_IDLE:
            begin
                if (i_conv_valid)
                begin
                    conv_rng_d = i_conv_range;
                    if (filter_en)
                    begin
                        acc_d = acc_sum;
                        cnt_d = cnt_q + 3'h1;
                        if (cnt_q == AVG_LAST)
                        begin
                            y_d     = 32'(acc_sum >>> AVG_SHIFT);
                            acc_d   = 35'h0;
                            state_d = S_M60;
                        end
                    end
                    else
                    begin
                        y_d     = x_corr;
                        state_d = S_M60;
                    end
                end
            end
            S_M60:
            begin
                if (mains60)
                    y_d = gain_stage(y_q, m60_off_q, m60_gain_q);
                state_d = S_VND;
            end
            S_VND:
            begin
                if (vnd_en)
                    y_d = gain_stage(y_q, vnd_off_q, vnd_gain_q);
                state_d = S_USR;
            end
            S_USR:
            begin
                if (user_en)
                    y_d = gain_stage(y_q, user_off[uidx], user_gain[uidx]);
                state_d = S_ACO;
            end
            S_ACO:
            begin
                if (y_q > 0 && 33'(y_q) < ac_twice)
                    y_d = (y_q - ac_so_q) <<< 1;
                state_d = S_CHK;
            end
            S_CHK:
            begin
                over_d  = y_q > ovf_limit;
                under_d = y_q < -ovf_limit - 32'sh1;
                inv_d   = conv_rng_q != range_q;
                valid_d = 1'b1;
                unique case (pres)
                    PRES_LEFT:
                    begin
                        if (y_q > 32'(FS_POS))
                            value_d = LEFT_MAX;
                        else if (y_q < 32'(FS_NEG))
                            value_d = LEFT_MIN;
                        else
                            value_d = 32'(y_q <<< LEFT_SHIFT);
                    end
                    PRES_RIGHT: value_d = y_q;
                    PRES_FLOAT: value_d = to_float(scaled);
                    default:    value_d = scaled;
                endcase
                if (i_autorange)
                begin
                    if (has_larger &&
                        mag > ((pres == PRES_LEFT) ? 32'(FS_POS) : 32'(UP_LIMIT)))
                        range_d = range_q + 3'h1;
                    else if (has_smaller &&
                             mag < ((pres == PRES_LEFT) ? 32'(DN_LEFT) : 32'(DN_LIMIT)))
                        range_d = range_q - 3'h1;
                end
                state_d = S_IDLE;
            end
            default: state_d = S_IDLE;
        endcase
        if (range_d != range_q)
        begin
            acc_d = 35'h0;
            cnt_d = 3'h0;
        end
        err_d = under_d | over_d | inv_d;
    end

    always_ff @(posedge i_clock)
    begin
        if (!i_rst_n)
        begin
            state_q    <= S_IDLE;
            acc_q      <= 35'h0;
            cnt_q      <= 3'h0;
            y_q        <= 32'h0;
            range_q    <= R_300V;
            conv_rng_q <= R_300V;
            ac_q       <= 1'b0;
            value_q    <= 32'h0;
            valid_q    <= 1'b0;
            under_q    <= 1'b0;
            over_q     <= 1'b0;
            inv_q      <= 1'b0;
            err_q      <= 1'b0;
        end
        else
        begin
            state_q    <= state_d;
            acc_q      <= acc_d;
            cnt_q      <= cnt_d;
            y_q        <= y_d;
            range_q    <= range_d;
            conv_rng_q <= conv_rng_d;
            ac_q       <= ac_d;
            value_q    <= value_d;
            valid_q    <= valid_d;
            under_q    <= under_d;
            over_q     <= over_d;
            inv_q      <= inv_d;
            err_q      <= err_d;
        end
    end

    assign o_rdata       = rdata_q;
    assign o_conv_start  = start_q;
    assign o_conv_range  = range_q;
    assign o_conv_ac     = ac_q;
    assign o_conv_60hz   = cfg_q[CFG_M60_BIT];
    assign o_zero_read   = zread_q;
    assign o_value       = value_q;
    assign o_value_valid = valid_q;
    assign o_under       = under_q;
    assign o_over        = over_q;
    assign o_invalid     = inv_q;
    assign o_error       = err_q;

endmodule

// *** verif/mm_value_checker_assertions.sv ***
module mm_value_checker
    import mm_value_pkg::*;
(
    input wire logic        i_clock,
    input wire logic        i_rst_n,
    input wire logic [7:0]  i_addr,
    input wire logic [31:0] i_wdata,
    input wire logic        i_wr,
    input wire logic        i_rd,
    input wire logic [31:0] o_rdata,
    input wire logic        i_conv_valid,
    input wire logic        i_offset_trigger,
    input wire logic        o_conv_start,
    input wire logic        o_conv_60hz,
    input wire logic        o_zero_read,
    input wire logic        o_value_valid,
    input wire logic        o_under,
    input wire logic        o_over,
    input wire logic        o_invalid,
    input wire logic        o_error
);
    timeunit 1ns;
    timeprecision 1ns;
    logic [31:0] cfg_q;
    logic [31:0] cfg_d;
    always_comb
    begin
        cfg_d = cfg_q;
        if (i_wr && i_addr == CFG_OFS)
            cfg_d = i_wdata & CFG_MASK;
    end
    always_ff @(posedge i_clock)
    begin
        cfg_q <= i_rst_n ? cfg_d : CFG_RESET;
    end
    default clocking @(posedge i_clock); endclocking
    default disable iff (!i_rst_n);
    sequence s_cfg_wr;
        i_wr && i_addr == CFG_OFS;
    endsequence
    sequence s_cfg_rd;
        i_rd && i_addr == CFG_OFS;
    endsequence
    property p_cfg_read; s_cfg_rd |=> o_rdata == cfg_q; endproperty
    a_cfg_read: assert property (p_cfg_read) else $error("config readback wrong");
    property p_err_or; o_error == (o_under || o_over || o_invalid); endproperty
    a_err_or: assert property (p_err_or) else $error("error flag wrong");
    property p_pub_lat; o_value_valid |-> $past(i_conv_valid, 6); endproperty
    a_pub_lat: assert property (p_pub_lat) else $error("publish latency wrong");
    property p_pub_pulse; o_value_valid |=> !o_value_valid; endproperty
    a_pub_pulse: assert property (p_pub_pulse) else $error("publish pulse too long");
    property p_m60; s_cfg_wr |=> o_conv_60hz == $past(i_wdata[CFG_M60_BIT]); endproperty
    a_m60: assert property (p_m60) else $error("mains mode not applied");
    property p_zero_trig;
        cfg_q[10:8] == ZCI_PDO && $rose(i_offset_trigger) |=> o_zero_read;
    endproperty
    a_zero_trig: assert property (p_zero_trig) else $error("zero read missing");
    property p_zero_off;
        cfg_q[10:8] == ZCI_OFF && $past(cfg_q[10:8]) == ZCI_OFF |-> !o_zero_read;
    endproperty
    a_zero_off: assert property (p_zero_off) else $error("zero read while off");
    property p_start_gap; o_conv_start |=> !o_conv_start [*8]; endproperty
    a_start_gap: assert property (p_start_gap) else $error("conversion restarted early");
    property p_start_period;
        o_conv_start && !$past(o_conv_60hz) |-> ##[49:51] (o_conv_start || o_conv_60hz);
    endproperty
    a_start_period: assert property (p_start_period) else $error("period wrong");
    property p_start_60;
        o_conv_start && $past(o_conv_60hz) |-> ##[39:41] o_conv_start;
    endproperty
    a_start_60: assert property (p_start_60) else $error("60 Hz period wrong");
endmodule

bind mm_value_proc mm_value_checker mm_value_checker_inst (
    .i_clock(i_clock), .i_rst_n(i_rst_n), .i_addr(i_addr), .i_wdata(i_wdata), .i_wr(i_wr),
    .i_rd(i_rd), .o_rdata(o_rdata), .i_conv_valid(i_conv_valid),
    .i_offset_trigger(i_offset_trigger), .o_conv_start(o_conv_start),
    .o_conv_60hz(o_conv_60hz), .o_zero_read(o_zero_read), .o_value_valid(o_value_valid),
    .o_under(o_under), .o_over(o_over), .o_invalid(o_invalid), .o_error(o_error));

// *** verif/conv_model.sv ***
module conv_model (
    input wire logic               i_clock,
    input wire logic               i_start,
    input wire logic [2:0]         i_range,
    input wire logic               i_zero_read,
    input wire logic signed [23:0] i_base,
    input wire logic [3:0]         i_step,
    input wire logic               i_bad,
    output logic                   o_valid,
    output logic signed [23:0]     o_raw,
    output logic [2:0]             o_range,
    output logic                   o_zero_valid,
    output logic signed [23:0]     o_zero
);
    timeunit 1ns;
    timeprecision 1ns;
    int         cnt = 0;
    logic       tog = 1'b0;
    logic [2:0] rng = 3'h0;
    initial {o_valid, o_raw, o_range, o_zero_valid, o_zero} = '0;
    always @(posedge i_clock)
    begin
        o_valid <= cnt == 1;
        o_zero_valid <= i_zero_read;
        o_zero <= 24'h000000;
        cnt <= i_start ? 20 : (cnt > 0 ? cnt - 1 : 0);
        if (i_start)
            rng <= i_range;
        if (cnt == 1)
        begin
            o_raw <= i_base + {20'h00000, tog ? i_step : 4'h0};
            o_range <= rng ^ {2'h0, i_bad};
            tog <= !tog;
        end
        else
            o_raw <= ~o_raw;
    end
endmodule

// *** verif/tb.sv ***
module tb
    import mm_value_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ns;
    logic i_clock = 0, i_rst_n = 0, i_wr = 0, i_rd = 0, i_autorange = 0;
    logic i_ac_mode = 0, i_offset_trigger = 0, i_conv_valid, i_zero_valid;
    logic o_conv_start, o_conv_ac, o_conv_60hz, o_zero_read, o_value_valid;
    logic o_under, o_over, o_invalid, o_error, bad = 0, seen;
    logic [7:0] i_addr = 8'h00;
    logic [31:0] i_wdata = 32'h0, o_rdata, o_value;
    logic signed [23:0] i_conv_raw, i_zero_value, base = 24'h0;
    logic [2:0] i_conv_range, o_conv_range, i_range_req = R_3V;
    logic [3:0] step = 4'h0;
    int fails = 0, total_checks = 0;
    mm_value_proc #(.INTEG_50_CYCLES(50), .INTEG_60_CYCLES(40)) mm_value_proc_inst (
        .i_clock(i_clock), .i_rst_n(i_rst_n), .i_addr(i_addr), .i_wdata(i_wdata),
        .i_wr(i_wr), .i_rd(i_rd), .o_rdata(o_rdata), .i_conv_valid(i_conv_valid),
        .i_conv_raw(i_conv_raw), .i_conv_range(i_conv_range), .i_zero_valid(i_zero_valid),
        .i_zero_value(i_zero_value), .o_conv_start(o_conv_start), .o_conv_range(o_conv_range),
        .o_conv_ac(o_conv_ac), .o_conv_60hz(o_conv_60hz), .o_zero_read(o_zero_read),
        .i_range_req(i_range_req), .i_autorange(i_autorange), .i_ac_mode(i_ac_mode),
        .i_offset_trigger(i_offset_trigger), .o_value(o_value), .o_value_valid(o_value_valid),
        .o_under(o_under), .o_over(o_over), .o_invalid(o_invalid), .o_error(o_error));
    conv_model conv_model_inst (.i_clock(i_clock), .i_start(o_conv_start),
        .i_range(o_conv_range), .i_zero_read(o_zero_read), .i_base(base), .i_step(step),
        .i_bad(bad), .o_valid(i_conv_valid), .o_raw(i_conv_raw), .o_range(i_conv_range),
        .o_zero_valid(i_zero_valid), .o_zero(i_zero_value));
    initial forever #50 i_clock = ~i_clock;
    task test_done;
        $display("checks %0d mismatches %0d", total_checks, fails);
        if (fails == 0 && total_checks > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    endtask
    task chk(input string n, input logic [31:0] e, input logic [31:0] g);
        total_checks++;
        if (g !== e)
        begin
            fails++;
            $display("Error %0s expected %h seen %h", n, e, g);
        end
    endtask
    task wr(input logic [7:0] a, input logic [31:0] d);
        i_addr <= a;
        i_wdata <= d;
        i_wr <= 1'b1;
        @(posedge i_clock);
        i_wr <= 1'b0;
        @(posedge i_clock);
    endtask
    task rd(input logic [7:0] a, input logic [31:0] e);
        i_addr <= a;
        i_rd <= 1'b1;
        @(posedge i_clock);
        i_rd <= 1'b0;
        @(negedge i_clock);
        chk("rdata", e, o_rdata);
        @(posedge i_clock);
    endtask
    task pub(input int n);
        for (int i = 0; i < 2000 && n > 0; i++)
        begin
            @(posedge i_clock);
            if (o_value_valid === 1'b1)
                n--;
        end
        if (n > 0)
        begin
            fails++;
            test_done();
        end
    endtask
    task run(input logic [31:0] c, input logic [2:0] r, input logic [23:0] b,
             input logic bd, input logic [31:0] ev, input logic [2:0] ef);
        wr(CFG_OFS, c);
        i_range_req <= r;
        base <= b;
        bad <= bd;
        pub(2);
        if (!bd)
            chk("value", ev, o_value);
        chk("flags", {29'h0, ef}, {29'h0, o_invalid, o_over, o_under});
        chk("error", {31'h0, |ef}, {31'h0, o_error});
        $display("test done, checks %0d", total_checks);
    endtask
    task ar(input logic [2:0] r, input logic [2:0] er, input logic [2:0] ef);
        run(32'h12, r, 24'h046CD0, 1'b0, 32'h00046CD0, ef);
        i_autorange <= 1'b1;
        pub(1);
        @(posedge i_clock);
        chk("range", {29'h0, er}, {29'h0, o_conv_range});
        i_autorange <= 1'b0;
    endtask
    initial
    begin
        repeat (2) @(posedge i_clock);
        i_rst_n <= 1'b1;
        @(posedge i_clock);
        rd(CFG_OFS, CFG_RESET);
        rd(VND_GAIN_OFS, 32'h2000);
        rd(8'h4C, 32'h2000);
        rd(8'hFC, 32'h0);
        run(32'h12, R_3V, 24'h020000, 1'b0, 32'h00020000, 3'h0);
        run(32'h1A, R_3V, 24'h020000, 1'b0, 32'h00020000, 3'h0);
        run(32'h22, R_3V, 24'h020000, 1'b0, 32'h0016E360, 3'h0);
        run(32'h02, R_3V, 24'h020000, 1'b0, 32'h40000000, 3'h0);
        run(32'h52, R_3V, 24'h020000, 1'b0, 32'h49B71B00, 3'h0);
        run(32'h22, R_300MV, 24'h020000, 1'b0, 32'h000249F0, 3'h0);
        run(32'h22, R_1A, 24'h020000, 1'b0, 32'h0007A120, 3'h0);
        run(32'h22, R_10A, 24'h020000, 1'b0, 32'h004C4B40, 3'h0);
        run(32'h12, R_3V, 24'h049958, 1'b0, 32'h00049958, 3'h0);
        run(32'h12, R_3V, 24'h0499BC, 1'b0, 32'h000499BC, 3'h2);
        run(32'h12, R_3V, 24'hFB6644, 1'b0, 32'hFFFB6644, 3'h1);
        run(32'h12, R_3V, 24'h020000, 1'b1, 32'h0, 3'h4);
        step <= 4'h8;
        run(32'h13, R_3V, 24'h0003E8, 1'b0, 32'h000003EC, 3'h0);
        step <= 4'h0;
        wr(8'h48, 32'h64);
        run(32'h16, R_3V, 24'h020000, 1'b0, 32'h0001FF9C, 3'h0);
        ar(R_3V, R_30V, 3'h0);
        ar(R_1A, R_1A, 3'h2);
        wr(AC_SO_OFS, 32'h10000);
        i_ac_mode <= 1'b1;
        run(32'h12, R_3V, 24'h018000, 1'b0, 32'h00010000, 3'h0);
        chk("conv_ac", 32'h1, {31'h0, o_conv_ac});
        i_ac_mode <= 1'b0;
        wr(CFG_OFS, 32'h412);
        i_offset_trigger <= 1'b1;
        seen = 1'b0;
        repeat (4)
        begin
            @(posedge i_clock);
            seen = seen | (o_zero_read === 1'b1);
        end
        chk("zero_read", 32'h1, {31'h0, seen});
        test_done();
    end
endmodule
